// ===== rtl/lfs_consts.svh
`ifndef LFS_CONSTS_SVH
`define LFS_CONSTS_SVH

// Data path widths
`define LFS_DW          16
`define LFS_PW          32
`define LFS_SLOTS       8
`define LFS_SELW        3
// Coefficients are signed with this many fraction bits; 1.0 is the unity entry
`define LFS_FRAC        14
`define LFS_UNITY       16'h4000
`define LFS_UNITY_SLOT  3'h7

// Filter cycle lengths in clocks
`define LFS_LAT_CYCLES  8
`define LFS_IIR_CYCLES  16
`define LFS_IIR_HALF    8

// Slot write control codes: bit 3 set means write the slot in bits 2:0
`define LFS_WC_HOLD     4'h0
`define LFS_WC_SHIFT    4'h1
`define LFS_WC_WRITE    1'b1

// Coefficient banks
`define LFS_BANK_LAT    2'h0
`define LFS_BANK_FB     2'h1
`define LFS_BANK_FF     2'h2
`define LFS_BANKS       3

// Output buffer
`define LFS_FIFO_DEPTH  16

// Timing: multiply then subtract must fit one clock
`define LFS_CLK_NS      100
`define LFS_MUL_NS      30
`define LFS_SUB_NS      25
`define LFS_PATH_NS     (`LFS_MUL_NS + `LFS_SUB_NS)
`define LFS_PATH_CYCLES ((`LFS_PATH_NS + `LFS_CLK_NS - 1) / `LFS_CLK_NS)

`endif

// ===== rtl/lfs_pkg.sv
package lfs_pkg;

    typedef logic signed [15:0] lfs_sample_t;
    typedef logic signed [31:0] lfs_prod_t;

    // One coefficient store write from the loading logic
    typedef struct packed {
        logic        we;
        logic [1:0]  bank;
        logic [2:0]  slot;
        lfs_sample_t data;
    } lfs_cwrite_s;

    typedef enum logic {
        ST_IDLE,
        ST_RUN
    } lfs_state_e;

endpackage

// ===== rtl/lfs_slot_store.sv
`include "lfs_consts.svh"

module lfs_slot_store #(
    parameter logic [15:0] INIT_LAST = 16'h0000
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // Write side
    input  wire logic                 clear,
    input  wire logic [3:0]           slot_write_control,
    input  wire lfs_pkg::lfs_sample_t wdata,
    // Read side
    input  wire logic [2:0]           slot_read_select,
    output lfs_pkg::lfs_sample_t      rdata
);
    lfs_pkg::lfs_sample_t mem [`LFS_SLOTS];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `LFS_SLOTS; i++) begin
                mem[i] <= (i == `LFS_SLOTS - 1) ? INIT_LAST : 16'h0000;
            end
        end else if (clear) begin
            for (int i = 0; i < `LFS_SLOTS; i++) begin
                mem[i] <= (i == `LFS_SLOTS - 1) ? INIT_LAST : 16'h0000;
            end
        end else if (slot_write_control == `LFS_WC_SHIFT) begin
            // Shift down; first slot keeps its value until rewritten
            for (int i = 1; i < `LFS_SLOTS; i++) begin
                mem[i] <= mem[i-1];
            end
        end else if (slot_write_control[3] == `LFS_WC_WRITE) begin
            mem[slot_write_control[2:0]] <= wdata;
        end
    end

    assign rdata = mem[slot_read_select];
endmodule

// ===== rtl/lfs_fifo.sv
module lfs_fifo #(
    parameter int W = 16,
    parameter int D = 16
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // Fill side
    input  wire logic                 s_valid,
    output logic                      s_ready,
    input  wire logic [W-1:0]         s_data,
    // Drain side
    output logic                      m_valid,
    input  wire logic                 m_ready,
    output logic [W-1:0]              m_data,
    // Fill level
    output logic [$clog2(D+1)-1:0]    level
);
    localparam int AW = $clog2(D);

    logic [W-1:0]           mem [D];
    logic [AW-1:0]          wr_q;
    logic [AW-1:0]          rd_q;
    logic [$clog2(D+1)-1:0] cnt_q;
    logic                   push;
    logic                   pop;

    assign s_ready = (cnt_q != ($clog2(D+1))'(D));
    assign m_valid = (cnt_q != '0);
    assign push    = s_valid && s_ready;
    assign pop     = m_valid && m_ready;
    assign m_data  = mem[rd_q];
    assign level   = cnt_q;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= s_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(D - 1)) ? '0 : wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(D - 1)) ? '0 : rd_q + AW'(1);
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + ($clog2(D+1))'(1);
            end else if (pop && !push) begin
                cnt_q <= cnt_q - ($clog2(D+1))'(1);
            end
        end
    end
endmodule

// ===== rtl/lfs_filter.sv
// How it works
// - Lattice mode chains N two-in two-out stages
// - Stage: forward/backward minus coefficient times other
// - Input sample feeds both first-stage inputs
// - Previous backward errors kept for next sample
// - Lattice filter cycle is eight clocks
// - Clock one: previous input, k0, new sample
// - Later clocks: next slot, next k, overwrite
// - Clock eight gives last forward error as output
// - Multiply then subtract within one clock
// - IIR: intermediate from feedback, output from feedforward
// - Three eight-slot stores: history, feedback, feedforward
// - Multiplexers route operands into the accumulator
// - IIR filter cycle is sixteen clocks
// - Clock one multiplies input by unity entry
// - Intermediate at clock nine, stored at ten
// - History shifts down at clock eight
// - IIR output ready at next cycle's first clock
// - Operands fetched by read select, not shifting
// - Sixteen-bit operands, full 32-bit accumulation
`include "lfs_consts.svh"

module lfs_filter (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    // Mode: 0 lattice FIR, 1 direct-form IIR
    input  wire logic                 mode_iir,
    // Sample input
    input  wire lfs_pkg::lfs_sample_t in_data,
    input  wire logic                 in_valid,
    output logic                      in_ready,
    // Coefficient loading
    input  wire lfs_pkg::lfs_cwrite_s coef_wr,
    // Filter output as presented
    output logic                      out_strobe,
    output lfs_pkg::lfs_sample_t      out_sample,
    // Buffered output stream
    output logic                      m_valid,
    input  wire logic                 m_ready,
    output lfs_pkg::lfs_sample_t      m_data
);
    // Reset synchroniser
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // Decoders shared by several stores
    function automatic logic [2:0] lfs_rsel(input logic [3:0] c);
        return ~c[2:0];
    endfunction

    function automatic logic [3:0] lfs_coef_wctl(input lfs_pkg::lfs_cwrite_s w,
                                                 input logic [1:0] bank);
        // Unity entry of the feedback bank is read only
        if (!w.we || w.bank != bank) begin
            return `LFS_WC_HOLD;
        end else if (bank == `LFS_BANK_FB && w.slot == `LFS_UNITY_SLOT) begin
            return `LFS_WC_HOLD;
        end else begin
            return {`LFS_WC_WRITE, w.slot};
        end
    endfunction

    function automatic lfs_pkg::lfs_sample_t lfs_scale(input lfs_pkg::lfs_prod_t p);
        lfs_pkg::lfs_prod_t s;
        s = p >>> `LFS_FRAC;
        return s[15:0];
    endfunction

    // Sequencer state
    lfs_pkg::lfs_state_e state_q;
    logic [3:0]          cnt_q;
    logic                mode_q;
    logic                in_ready_q;
    logic                restart;
    logic                take;
    logic                active;
    logic                last;
    logic [3:0]          cyc;
    logic                lat_on;
    logic                iir_on;

    // Data path
    lfs_pkg::lfs_sample_t hist_rd;
    lfs_pkg::lfs_sample_t coef_rd [`LFS_BANKS];
    logic [2:0]           coef_sel [`LFS_BANKS];
    logic [2:0]           slot_read_select;
    logic [3:0]           slot_write_control;
    lfs_pkg::lfs_sample_t hist_wdata;
    lfs_pkg::lfs_sample_t ef_in;
    lfs_pkg::lfs_sample_t ef_new;
    lfs_pkg::lfs_sample_t eb_new;
    lfs_pkg::lfs_prod_t   prod_f;
    lfs_pkg::lfs_prod_t   prod_b;
    lfs_pkg::lfs_sample_t ef_q;
    lfs_pkg::lfs_sample_t eb_q;
    lfs_pkg::lfs_sample_t mac_x;
    lfs_pkg::lfs_sample_t mac_y;
    lfs_pkg::lfs_prod_t   mac_p;
    lfs_pkg::lfs_prod_t   acc_d;
    lfs_pkg::lfs_prod_t   acc_q;
    lfs_pkg::lfs_sample_t w_q;
    logic                 out_strobe_q;
    logic                 out_strobe_d;
    lfs_pkg::lfs_sample_t out_sample_q;
    lfs_pkg::lfs_sample_t out_sample_d;
    logic                 fifo_ready;
    logic [4:0]           fifo_level;
    logic                 room;

    // Sequence control
    assign restart = (mode_iir != mode_q);
    assign take    = in_valid && in_ready_q && !restart;
    assign active  = take || (state_q == lfs_pkg::ST_RUN && !restart);
    assign cyc     = take ? 4'h0 : cnt_q;
    assign lat_on  = active && !mode_q;
    assign iir_on  = active && mode_q;
    assign last    = mode_q ? (cnt_q == 4'(`LFS_IIR_CYCLES - 1))
                            : (cnt_q == 4'(`LFS_LAT_CYCLES - 1));
    // Keeps room for the pending output plus the one this sample will make
    assign room    = (fifo_level < 5'(`LFS_FIFO_DEPTH - 1)) && fifo_ready;

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mode_q <= 1'b0;
        end else begin
            mode_q <= mode_iir;
        end
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q    <= lfs_pkg::ST_IDLE;
            cnt_q      <= 4'h0;
            in_ready_q <= 1'b0;
        end else if (restart) begin
            state_q    <= lfs_pkg::ST_IDLE;
            cnt_q      <= 4'h0;
            in_ready_q <= 1'b0;
        end else begin
            case (state_q)
                lfs_pkg::ST_IDLE: begin
                    if (take) begin
                        state_q    <= lfs_pkg::ST_RUN;
                        cnt_q      <= 4'h1;
                        in_ready_q <= 1'b0;
                    end else begin
                        in_ready_q <= room;
                    end
                end
                lfs_pkg::ST_RUN: begin
                    if (last) begin
                        state_q    <= lfs_pkg::ST_IDLE;
                        cnt_q      <= 4'h0;
                        in_ready_q <= room;
                    end else begin
                        cnt_q <= cnt_q + 4'h1;
                    end
                end
                default: begin
                    state_q    <= lfs_pkg::ST_IDLE;
                    cnt_q      <= 4'h0;
                    in_ready_q <= 1'b0;
                end
            endcase
        end
    end

    // Operand fetch by read select; stores are never shifted per clock
    assign slot_read_select = lfs_rsel(cyc);
    assign coef_sel[`LFS_BANK_LAT] = cyc[2:0];
    assign coef_sel[`LFS_BANK_FB]  = lfs_rsel(cyc);
    assign coef_sel[`LFS_BANK_FF]  = lfs_rsel(cyc);

    // Coefficient stores, loaded by the outside logic
    genvar g;
    generate
        for (g = 0; g < `LFS_BANKS; g++) begin : g_coef
            lfs_slot_store #(
                .INIT_LAST ((g == `LFS_BANK_FB) ? `LFS_UNITY : 16'h0000)
            ) u_coef (
                .clk                (clk),
                .rst_n              (rst_n_q),
                .clear              (1'b0),
                .slot_write_control (lfs_coef_wctl(coef_wr, 2'(g))),
                .wdata              (coef_wr.data),
                .slot_read_select   (coef_sel[g]),
                .rdata              (coef_rd[g])
            );
        end
    endgenerate

    // History store write control
    always_comb begin
        slot_write_control = `LFS_WC_HOLD;
        hist_wdata         = eb_q;
        if (lat_on) begin
            // New sample into the last slot, then each fresh backward error
            slot_write_control = {`LFS_WC_WRITE, lfs_rsel(cyc)};
            hist_wdata         = (cyc == 4'h0) ? in_data : eb_q;
        end else if (iir_on) begin
            if (cyc == 4'(`LFS_IIR_HALF - 1)) begin
                slot_write_control = `LFS_WC_SHIFT;
            end else if (cyc == 4'(`LFS_IIR_HALF + 1)) begin
                slot_write_control = {`LFS_WC_WRITE, 3'h0};
                hist_wdata         = w_q;
            end
        end
    end

    lfs_slot_store #(
        .INIT_LAST (16'h0000)
    ) u_hist (
        .clk                (clk),
        .rst_n              (rst_n_q),
        .clear              (restart),
        .slot_write_control (slot_write_control),
        .wdata              (hist_wdata),
        .slot_read_select   (slot_read_select),
        .rdata              (hist_rd)
    );

    // Lattice stage: two multipliers then two subtractors, one clock
    assign ef_in  = (cyc == 4'h0) ? in_data : ef_q;
    assign prod_f = coef_rd[`LFS_BANK_LAT] * hist_rd;
    assign prod_b = coef_rd[`LFS_BANK_LAT] * ef_in;
    assign ef_new = ef_in - lfs_scale(prod_f);
    assign eb_new = hist_rd - lfs_scale(prod_b);

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ef_q <= 16'h0000;
            eb_q <= 16'h0000;
        end else if (lat_on) begin
            ef_q <= ef_new;
            eb_q <= eb_new;
        end
    end

    // Single multiplier-accumulator for the IIR
    assign mac_x = (cyc == 4'h0) ? in_data : hist_rd;
    assign mac_y = (cyc < 4'(`LFS_IIR_HALF)) ? coef_rd[`LFS_BANK_FB]
                                             : coef_rd[`LFS_BANK_FF];
    assign mac_p = mac_x * mac_y;
    // Accumulation restarts at clocks one and nine; no rounding in between
    assign acc_d = ((cyc == 4'h0 || cyc == 4'(`LFS_IIR_HALF)) ? 32'h0000_0000 : acc_q)
                   + mac_p;

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            acc_q <= 32'h0000_0000;
        end else if (restart) begin
            acc_q <= 32'h0000_0000;
        end else if (iir_on) begin
            acc_q <= acc_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            w_q <= 16'h0000;
        end else if (iir_on && cyc == 4'(`LFS_IIR_HALF)) begin
            w_q <= lfs_scale(acc_q);
        end
    end

    // Output presentation
    always_comb begin
        out_strobe_d = 1'b0;
        out_sample_d = out_sample_q;
        if (lat_on && cyc == 4'(`LFS_LAT_CYCLES - 1)) begin
            out_strobe_d = 1'b1;
            out_sample_d = ef_new;
        end else if (iir_on && cyc == 4'(`LFS_IIR_CYCLES - 1)) begin
            out_strobe_d = 1'b1;
            out_sample_d = lfs_scale(acc_d);
        end
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            out_strobe_q <= 1'b0;
            out_sample_q <= 16'h0000;
        end else begin
            out_strobe_q <= out_strobe_d;
            out_sample_q <= out_sample_d;
        end
    end

    // Output buffer; when it nears full no further sample is taken
    lfs_fifo #(
        .W (`LFS_DW),
        .D (`LFS_FIFO_DEPTH)
    ) u_fifo (
        .clk     (clk),
        .rst_n   (rst_n_q),
        .s_valid (out_strobe_q),
        .s_ready (fifo_ready),
        .s_data  (out_sample_q),
        .m_valid (m_valid),
        .m_ready (m_ready),
        .m_data  (m_data),
        .level   (fifo_level)
    );

    assign in_ready   = in_ready_q;
    assign out_strobe = out_strobe_q;
    assign out_sample = out_sample_q;
endmodule

// ===== sim/lfs_filter_assertions.sv
module lfs_filter_chk (
    // Clock and reset
    input wire logic                 clk,
    input wire logic                 reset_n,
    // Control and sample side
    input wire logic                 mode_iir,
    input wire logic                 in_valid,
    input wire logic                 in_ready,
    // Output side
    input wire logic                 out_strobe,
    input wire lfs_pkg::lfs_sample_t out_sample,
    input wire logic                 m_valid,
    input wire logic                 m_ready,
    input wire lfs_pkg::lfs_sample_t m_data
);
    logic take;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // Offers in the cycle of a mode change are refused, hence the stable terms
    assign take = in_valid && in_ready;

    chk_lat_answer: assert property ((take && !mode_iir && $stable(mode_iir))
        ##1 $stable(mode_iir) [*8] |-> out_strobe)
        else $error("lattice output not on clock eight");
    chk_iir_answer: assert property ((take && mode_iir && $stable(mode_iir))
        ##1 $stable(mode_iir) [*8] ##1 $stable(mode_iir) [*8] |-> out_strobe)
        else $error("iir output not on clock sixteen");
    chk_busy_quiet: assert property (take && $stable(mode_iir) |=>
        (!in_ready && !out_strobe) [*7])
        else $error("ready or strobe inside a filter cycle");
    chk_strobe_pulse: assert property (out_strobe |=> !out_strobe)
        else $error("output strobe longer than one clock");
    chk_sample_hold: assert property (!out_strobe |-> $stable(out_sample))
        else $error("output changed without strobe");
    chk_mode_ready: assert property ($changed(mode_iir) |=> !in_ready)
        else $error("ready right after a mode change");
    chk_mode_abort: assert property ($changed(mode_iir) |=> !out_strobe [*4])
        else $error("strobe after an aborted cycle");
    chk_fifo_entry: assert property (out_strobe && !m_valid |=>
        m_valid && m_data == $past(out_sample))
        else $error("fresh output not at buffer head");

    cov_lat_take: cover property (take && !mode_iir);
    cov_iir_take: cover property (take && mode_iir);
    cov_full_stall: cover property (m_valid && !m_ready && !in_ready);
endmodule

bind lfs_filter lfs_filter_chk u_chk (
    .clk        (clk),
    .reset_n    (reset_n),
    .mode_iir   (mode_iir),
    .in_valid   (in_valid),
    .in_ready   (in_ready),
    .out_strobe (out_strobe),
    .out_sample (out_sample),
    .m_valid    (m_valid),
    .m_ready    (m_ready),
    .m_data     (m_data)
);

// ===== sim/lfs_sink.sv
module lfs_sink (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // Stream from the filter
    input  wire logic                 m_valid,
    output logic                      m_ready,
    input  wire lfs_pkg::lfs_sample_t m_data,
    // Hold off the consumer entirely
    input  wire logic                 stall
);
    timeunit 1ns;
    timeprecision 1ns;

    lfs_pkg::lfs_sample_t got[$];
    logic [1:0]           pace_q;

    // Slow consumer: refuses one clock in four so the buffer sees back-pressure
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pace_q  <= 2'h0;
            m_ready <= 1'b0;
        end else begin
            pace_q  <= pace_q + 2'h1;
            m_ready <= !stall && (pace_q != 2'h3);
        end
    end

    always_ff @(posedge clk) begin
        if (m_valid && m_ready) begin
            got.push_back(m_data);
        end
    end
endmodule

// ===== sim/tb.sv
`include "lfs_consts.svh"

module tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic                 clk;
    logic                 reset_n;
    logic                 mode_iir;
    lfs_pkg::lfs_sample_t in_data;
    logic                 in_valid;
    logic                 in_ready;
    lfs_pkg::lfs_cwrite_s coef_wr;
    logic                 out_strobe;
    lfs_pkg::lfs_sample_t out_sample;
    logic                 m_valid;
    logic                 m_ready;
    lfs_pkg::lfs_sample_t m_data;
    logic                 stall;
    int                   fails;
    int                   compares;
    // Reference coefficients and histories
    lfs_pkg::lfs_sample_t kc[8];
    lfs_pkg::lfs_sample_t bc[8];
    lfs_pkg::lfs_sample_t ac[8];
    lfs_pkg::lfs_sample_t ebh[8];
    lfs_pkg::lfs_sample_t wh[8];
    lfs_pkg::lfs_sample_t exp_q[$];
    lfs_pkg::lfs_sample_t xs[4] = '{16'h1234, 16'hedcb, 16'h7fff, 16'h8000};

    lfs_filter u_dut (
        .clk        (clk),
        .reset_n    (reset_n),
        .mode_iir   (mode_iir),
        .in_data    (in_data),
        .in_valid   (in_valid),
        .in_ready   (in_ready),
        .coef_wr    (coef_wr),
        .out_strobe (out_strobe),
        .out_sample (out_sample),
        .m_valid    (m_valid),
        .m_ready    (m_ready),
        .m_data     (m_data)
    );

    lfs_sink u_sink (
        .clk     (clk),
        .rst_n   (reset_n),
        .m_valid (m_valid),
        .m_ready (m_ready),
        .m_data  (m_data),
        .stall   (stall)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic print_verdict();
        if (fails == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic lfs_pkg::lfs_sample_t lat_step(lfs_pkg::lfs_sample_t u);
        lfs_pkg::lfs_sample_t ef;
        lfs_pkg::lfs_sample_t eb;
        lfs_pkg::lfs_sample_t nb;
        lfs_pkg::lfs_prod_t   p;
        ef = u;
        eb = u;
        for (int m = 0; m < 8; m++) begin
            p = kc[m] * ef;
            nb = ebh[m] - lfs_pkg::lfs_sample_t'(p >>> `LFS_FRAC);
            p = kc[m] * ebh[m];
            ef = ef - lfs_pkg::lfs_sample_t'(p >>> `LFS_FRAC);
            ebh[m] = eb;
            eb = nb;
        end
        return ef;
    endfunction

    function automatic lfs_pkg::lfs_sample_t iir_step(lfs_pkg::lfs_sample_t u);
        lfs_pkg::lfs_prod_t acc;
        acc = u;
        acc = acc <<< `LFS_FRAC;
        for (int j = 0; j < 7; j++) begin
            acc = acc + bc[j] * wh[j];
        end
        for (int j = 7; j > 0; j--) begin
            wh[j] = wh[j - 1];
        end
        wh[0] = lfs_pkg::lfs_sample_t'(acc >>> `LFS_FRAC);
        acc = '0;
        for (int j = 0; j < 8; j++) begin
            acc = acc + ac[j] * wh[j];
        end
        return lfs_pkg::lfs_sample_t'(acc >>> `LFS_FRAC);
    endfunction

    task automatic clear_hist();
        ebh = '{default: '0};
        wh  = '{default: '0};
    endtask

    task automatic wcoef(input logic [1:0] bank, input int slot, input lfs_pkg::lfs_sample_t d);
        @(posedge clk);
        coef_wr <= {1'b1, bank, 3'(slot), d};
    endtask

    task automatic offer(input lfs_pkg::lfs_sample_t x);
        int n;
        n = 0;
        @(posedge clk);
        coef_wr  <= '0;
        in_data  <= x;
        in_valid <= 1'b1;
        do begin
            @(negedge clk);
            n++;
        end while (in_ready !== 1'b1 && n < 300);
        check(n < 300, 1'b1);
        @(posedge clk);
        in_valid <= 1'b0;
    endtask

    task automatic run_sample(input lfs_pkg::lfs_sample_t x, input int lat,
                              input lfs_pkg::lfs_sample_t y);
        int n;
        n = 0;
        offer(x);
        exp_q.push_back(y);
        do begin
            @(negedge clk);
            n++;
            if (n < lat) check(in_ready, 1'b0);
        end while (out_strobe !== 1'b1 && n < 40);
        check(n, lat);
        check(out_sample, y);
    endtask

    task automatic t_reset();
        repeat (3) begin
            @(negedge clk);
            check({in_ready, out_strobe, m_valid}, 3'h0);
        end
        @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask

    task automatic t_lattice();
        run_sample(16'h0a5a, `LFS_LAT_CYCLES, lat_step(16'h0a5a));
        kc = '{16'h1000, 16'hf000, 16'h0800, 16'h2000, 16'he000, 16'h0400, 16'h0c00, 16'hfc00};
        foreach (kc[m]) wcoef(`LFS_BANK_LAT, m, kc[m]);
        foreach (xs[i]) begin
            run_sample(xs[i], `LFS_LAT_CYCLES, lat_step(xs[i]));
        end
    endtask

    task automatic t_iir();
        @(posedge clk);
        mode_iir <= 1'b1;
        clear_hist();
        bc = '{16'h2000, 16'hf000, 16'h0800, 16'hfc00, 16'h0400, 16'hfe00, 16'h0200, 16'h0000};
        ac = '{16'h1000, 16'h0800, 16'hf800, 16'h0400, 16'h0c00, 16'hfc00, 16'h0200, 16'h0100};
        // Unity slot must ignore the zero, bank 3 must ignore everything
        for (int j = 0; j < 8; j++) begin
            wcoef(`LFS_BANK_FB, j, bc[j]);
            wcoef(`LFS_BANK_FF, j, ac[j]);
            wcoef(2'h3, j, 16'h7777);
        end
        foreach (xs[i]) begin
            run_sample(xs[i], `LFS_IIR_CYCLES, iir_step(xs[i]));
        end
    endtask

    task automatic t_abort();
        offer(16'h4321);
        repeat (5) @(posedge clk);
        mode_iir <= 1'b0;
        clear_hist();
        repeat (20) begin
            @(negedge clk);
            check(out_strobe, 1'b0);
        end
        run_sample(16'h3c3c, `LFS_LAT_CYCLES, lat_step(16'h3c3c));
    endtask

    task automatic t_fifo();
        int n;
        lfs_pkg::lfs_sample_t x;
        n = 0;
        while (m_valid !== 1'b0 && n < 100) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        stall <= 1'b1;
        for (int i = 0; i < `LFS_FIFO_DEPTH - 1; i++) begin
            x = lfs_pkg::lfs_sample_t'(16'h0457 * i - 16'h1a00);
            run_sample(x, `LFS_LAT_CYCLES, lat_step(x));
        end
        // Ready may stand one clock more, judged on the level before the push
        @(negedge clk);
        check(m_valid, 1'b1);
        repeat (12) begin
            @(negedge clk);
            check({in_ready, m_valid}, 2'h1);
        end
        @(posedge clk);
        stall <= 1'b0;
        n = 0;
        while (m_valid !== 1'b0 && n < 200) begin
            @(negedge clk);
            n++;
        end
        check(u_sink.got.size(), exp_q.size());
        foreach (exp_q[i]) check(u_sink.got[i], exp_q[i]);
    endtask

    // Roughly 360 clocks of traffic; a hang ends the run well after that
    initial begin
        repeat (6000) @(posedge clk);
        fails++;
        print_verdict();
    end

    initial begin
        reset_n  = 1'b0;
        mode_iir = 1'b0;
        in_data  = 16'h0000;
        in_valid = 1'b0;
        coef_wr  = '0;
        stall    = 1'b0;
        fails    = 0;
        compares = 0;
        kc = '{default: '0};
        clear_hist();
        t_reset();
        t_lattice();
        t_iir();
        t_abort();
        t_fifo();
        print_verdict();
    end
endmodule
